// ==== rtl/iocad_decode.sv ====
// Selector register and configuration access routing decode
`timescale 1ns/1ps
module iocad_decode (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        io_valid,
   input  wire logic        io_write,
   input  wire logic [15:0] io_addr,
   input  wire logic [3:0]  io_be,
   input  wire logic [31:0] io_wdata,
   input  wire logic [7:0]  secondary_bus,
   input  wire logic [7:0]  subordinate_bus,
   output logic      [31:0] io_rdata,
   output logic             io_rvalid,
   output logic             io_pass,
   output logic             cfg_launch,
   output logic             cfg_write,
   output logic [3:0]       cfg_be,
   output logic [31:0]      cfg_wdata,
   output logic [2:0]       cfg_route,
   output logic [31:0]      hub_addr,
   output logic [7:0]       hdr_byte6,
   output logic [7:0]       hdr_byte7,
   output logic [7:0]       hdr_byte8,
   output logic [7:0]       hdr_byte9
);

   logic [31:0]     config_selector;
   logic            sel_hit;
   logic            data_hit;
   logic            full_dw;
   logic            cfg_space_on;
   logic [7:0]      bus_num;
   logic [4:0]      dev_num;
   logic [2:0]      func_num;
   logic [5:0]      reg_num;
   iocad_pkg::iocad_route_type next_route;
   logic            sel_write;
   logic            sel_read;
   logic            sel_narrow;
   logic            launch_hit;
   logic [7:0]      hub_bus;

   ////////////////////////////////////////////////////////////////////////
   // Decode helpers shared between processes
   // Full doubleword access to one I/O port
   function automatic logic iocad_dw_hit(input logic        valid,
                                         input logic [15:0] addr,
                                         input logic [15:0] port,
                                         input logic [3:0]  be);
      iocad_dw_hit = valid && (addr == port) && (be == iocad_pkg::FULL_DWORD_BE);
   endfunction

   // Internal devices answer only functions 0 and 1
   function automatic logic iocad_int_func_ok(input logic [2:0] func);
      iocad_int_func_ok = (func <= iocad_pkg::MAX_INT_FUNC);
   endfunction

   // Non-zero bus that names the bridge secondary bus itself
   function automatic logic iocad_on_secondary(input logic [7:0] bus,
                                               input logic [7:0] sec);
      iocad_on_secondary = (bus != 8'h00) && (bus == sec);
   endfunction

   // Bus behind the bridge but past its secondary bus
   function automatic logic iocad_below_bridge(input logic [7:0] bus,
                                               input logic [7:0] sec,
                                               input logic [7:0] sub);
      iocad_below_bridge = (bus > sec) && (bus <= sub);
   endfunction

   // Device and function byte for hub address bits 15:8 and header byte 9
   function automatic logic [7:0] iocad_dev_func(input logic [4:0] dev,
                                                 input logic [2:0] func);
      iocad_dev_func = {dev, func};
   endfunction

   // Register byte with the two low address bits cleared
   function automatic logic [7:0] iocad_reg_byte(input logic [5:0] regn);
      iocad_reg_byte = {regn, 2'b00};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Field extraction
   assign sel_hit      = io_valid && (io_addr == iocad_pkg::SELECTOR_ADDR);
   assign data_hit     = io_valid && (io_addr == iocad_pkg::DATA_ADDR);
   assign full_dw      = (io_be == iocad_pkg::FULL_DWORD_BE);
   assign cfg_space_on = config_selector[iocad_pkg::ENABLE_BIT];

   // Selector fields, reserved bits never steer anything
   assign bus_num      = config_selector[iocad_pkg::BUS_HI:iocad_pkg::BUS_LO];
   assign dev_num      = config_selector[iocad_pkg::DEV_HI:iocad_pkg::DEV_LO];
   assign func_num     = config_selector[iocad_pkg::FUNC_HI:iocad_pkg::FUNC_LO];
   assign reg_num      = config_selector[iocad_pkg::REG_HI:iocad_pkg::REG_LO];

   ////////////////////////////////////////////////////////////////////////
   // Access qualifiers shared by the selector, read and launch paths
   assign sel_write  = iocad_dw_hit(io_valid, io_addr, iocad_pkg::SELECTOR_ADDR, io_be) && io_write;
   assign sel_read   = iocad_dw_hit(io_valid, io_addr, iocad_pkg::SELECTOR_ADDR, io_be) && !io_write;
   assign sel_narrow = sel_hit && !full_dw;
   assign launch_hit = data_hit && cfg_space_on;
   // Bus field reaches the hub address only on Type 1, Type 0 carries zero
   assign hub_bus    = (next_route == iocad_pkg::IOCAD_ROUTE_HUB_T1) ? bus_num : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Selector register, doubleword writes only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         config_selector <= iocad_pkg::SELECTOR_RESET;
      end else if (sel_write) begin
         config_selector <= io_wdata & iocad_pkg::SELECTOR_WMASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Route decision
   always_comb begin
      next_route = iocad_pkg::IOCAD_ROUTE_NONE;
      if (bus_num == 8'h00) begin
         if (dev_num >= iocad_pkg::FIRST_EXT_DEV) begin
            next_route = iocad_pkg::IOCAD_ROUTE_HUB_T0;
         end else if (iocad_int_func_ok(func_num)) begin
            next_route = iocad_pkg::IOCAD_ROUTE_INTERNAL;
         end else begin
            next_route = iocad_pkg::IOCAD_ROUTE_NONE;
         end
      end else if (iocad_on_secondary(bus_num, secondary_bus)) begin
         next_route = iocad_pkg::IOCAD_ROUTE_PCIE_T0;
      end else if (iocad_below_bridge(bus_num, secondary_bus, subordinate_bus)) begin
         next_route = iocad_pkg::IOCAD_ROUTE_PCIE_T1;
      end else begin
         next_route = iocad_pkg::IOCAD_ROUTE_HUB_T1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Launch pulse, one cycle after the data window access
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_launch <= 1'b0;
      end else begin
         cfg_launch <= launch_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transaction qualifiers, held until the next launch
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_write <= 1'b0;
         cfg_be    <= 4'h0;
         cfg_wdata <= 32'h00000000;
         cfg_route <= 3'h0;
      end else if (launch_hit) begin
         cfg_write <= io_write;
         cfg_be    <= io_be;
         cfg_wdata <= io_wdata;
         cfg_route <= next_route;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Hub link address, bus field only on Type 1
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hub_addr <= 32'h00000000;
      end else if (launch_hit) begin
         hub_addr <= {8'h00, // Upper byte unused by the hub link
                      hub_bus,
                      iocad_dev_func(dev_num, func_num),
                      iocad_reg_byte(reg_num)};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link request header bytes 6 to 9
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hdr_byte6 <= 8'h00;
         hdr_byte7 <= 8'h00;
         hdr_byte8 <= 8'h00;
         hdr_byte9 <= 8'h00;
      end else if (launch_hit) begin
         hdr_byte6 <= {5'h00, func_num};
         hdr_byte7 <= iocad_reg_byte(reg_num);
         hdr_byte8 <= bus_num;
         hdr_byte9 <= iocad_dev_func(dev_num, func_num);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read valid and pass-through pulses, one cycle each
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         io_rvalid <= 1'b0;
         io_pass   <= 1'b0;
      end else begin
         io_rvalid <= sel_read;
         io_pass   <= sel_narrow;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Selector read data, reserved bits already cleared at write
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         io_rdata <= 32'h00000000;
      end else if (sel_read) begin
         io_rdata <= config_selector;
      end
   end

endmodule

// ==== rtl/iocad_pkg.sv ====
// Package: constants for the I/O configuration address decode block
package iocad_pkg;
   localparam logic [15:0] SELECTOR_ADDR   = 16'h0CF8;
   localparam logic [15:0] DATA_ADDR       = 16'h0CFC;
   localparam logic [31:0] SELECTOR_RESET  = 32'h00000000;
   localparam logic [31:0] SELECTOR_WMASK  = 32'h80FFFFFC;
   localparam int          ENABLE_BIT      = 31;
   localparam int          BUS_HI          = 23;
   localparam int          BUS_LO          = 16;
   localparam int          DEV_HI          = 15;
   localparam int          DEV_LO          = 11;
   localparam int          FUNC_HI         = 10;
   localparam int          FUNC_LO         = 8;
   localparam int          REG_HI          = 7;
   localparam int          REG_LO          = 2;
   localparam logic [4:0]  FIRST_EXT_DEV   = 5'h02;
   localparam logic [2:0]  MAX_INT_FUNC    = 3'h1;
   localparam logic [3:0]  FULL_DWORD_BE   = 4'hF;
   typedef enum logic [2:0] {
      IOCAD_ROUTE_NONE, IOCAD_ROUTE_INTERNAL, IOCAD_ROUTE_HUB_T0,
      IOCAD_ROUTE_HUB_T1, IOCAD_ROUTE_PCIE_T0, IOCAD_ROUTE_PCIE_T1
   } iocad_route_type;
endpackage

// ==== sim/iocad_decode_monitor.sv ====
// Checker on the decode block ports
`timescale 1ns/1ps
module iocad_decode_monitor (
   input wire logic        clk, arst_n, io_valid, io_write, io_rvalid, io_pass, cfg_launch,
   input wire logic [15:0] io_addr,
   input wire logic [3:0]  io_be,
   input wire logic [2:0]  cfg_route,
   input wire logic [31:0] io_wdata, io_rdata, hub_addr,
   input wire logic [7:0]  secondary_bus, subordinate_bus, hdr_byte8, hdr_byte9
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Selector doubleword write and data window access
   sequence s_wr; io_valid && io_write && io_addr == 16'h0CF8 && io_be == 4'hF; endsequence
   sequence s_dat; io_valid && io_addr == 16'h0CFC; endsequence
   AST_PASS: assert property (io_valid && io_addr == 16'h0CF8 && io_be != 4'hF |=> io_pass)
      else $error("narrow access kept");
   AST_MASK: assert property (s_wr ##1 (io_valid && !io_write && io_addr == 16'h0CF8 && io_be == 4'hF)
      |=> io_rvalid && io_rdata == ($past(io_wdata, 2) & 32'h80FFFFFC)) else $error("bad readback");
   AST_OFF: assert property (s_wr ##0 !io_wdata[31] ##1 s_dat |=> !cfg_launch) else $error("launch while off");
   AST_ON: assert property (s_wr ##0 io_wdata[31] ##1 s_dat |=> cfg_launch) else $error("no launch");
   AST_T0: assert property (cfg_launch && cfg_route == 3'h2 |-> hdr_byte8 == 8'h00 && hdr_byte9[7:3] >= 5'h02)
      else $error("bad hub type 0");
   AST_T1: assert property (cfg_launch && cfg_route == 3'h3 |-> hub_addr[23:16] == hdr_byte8 && hdr_byte8 != 8'h00
      && (hdr_byte8 < $past(secondary_bus) || hdr_byte8 > $past(subordinate_bus))) else $error("bad hub type 1");
   AST_P0: assert property (cfg_launch && cfg_route == 3'h4 |-> hdr_byte8 != 8'h00 && hdr_byte8 == $past(secondary_bus))
      else $error("bad link type 0");
   AST_P1: assert property (cfg_launch && cfg_route == 3'h5 |-> hdr_byte8 > $past(secondary_bus)
      && hdr_byte8 <= $past(subordinate_bus)) else $error("bad link type 1");
   AST_INT: assert property (cfg_launch && cfg_route == 3'h1 |-> hdr_byte8 == 8'h00 && hdr_byte9[7:3] < 5'h02
      && hdr_byte9[2:0] <= 3'h1) else $error("bad internal claim");
endmodule
bind iocad_decode iocad_decode_monitor u_iocad_decode_monitor (.clk, .arst_n, .io_valid, .io_write, .io_rvalid,
   .io_pass, .cfg_launch, .io_addr, .io_be, .cfg_route, .io_wdata, .io_rdata, .hub_addr, .secondary_bus,
   .subordinate_bus, .hdr_byte8, .hdr_byte9);

// ==== sim/iocad_host.sv ====
// Processor-side model issuing I/O accesses, with bridge bus numbers
`timescale 1ns/1ps
module iocad_host (
   input  wire logic        clk,
   output logic             io_valid, io_write,
   output logic [15:0]      io_addr,
   output logic [3:0]       io_be,
   output logic [31:0]      io_wdata,
   output logic [7:0]       secondary_bus, subordinate_bus
);
   // Idle port and fixed bridge window 05h..08h
   initial begin
      {io_valid, io_write, io_addr, io_be, io_wdata} = '0;
      secondary_bus = 8'h05;
      subordinate_bus = 8'h08;
   end
   // One access per clock, idle data shows the inverse of the last
   task automatic acc(input logic v, w, input logic [15:0] a, input logic [3:0] b, input logic [31:0] d);
      io_valid = v;
      io_write = w;
      io_addr = a;
      io_be = b;
      io_wdata = v ? d : ~io_wdata;
      @(posedge clk);
      #1;
   endtask
endmodule

// ==== sim/test_io_config_address_decode.sv ====
// Self-checking bench for selector capture and routing
`timescale 1ns/1ps
module test_io_config_address_decode;
   logic        clk, arst_n, io_valid, io_write, io_rvalid, io_pass, cfg_launch, cfg_write;
   logic [15:0] io_addr;
   logic [3:0]  io_be, cfg_be;
   logic [2:0]  cfg_route;
   logic [31:0] io_wdata, io_rdata, cfg_wdata, hub_addr;
   logic [7:0]  secondary_bus, subordinate_bus, hdr_byte6, hdr_byte7, hdr_byte8, hdr_byte9;
   int          bad_count = 0;
   int          cmp_count = 0;
   iocad_host u_iocad_host (.clk, .io_valid, .io_write, .io_addr, .io_be, .io_wdata, .secondary_bus, .subordinate_bus);
   iocad_decode u_iocad_decode (.clk, .arst_n, .io_valid, .io_write, .io_addr, .io_be, .io_wdata, .secondary_bus,
      .subordinate_bus, .io_rdata, .io_rvalid, .io_pass, .cfg_launch, .cfg_write, .cfg_be, .cfg_wdata, .cfg_route,
      .hub_addr, .hdr_byte6, .hdr_byte7, .hdr_byte8, .hdr_byte9);
   ////////////////////////////////////////////////////////////
   // Clock, compare and verdict
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [47:0] s, e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic print_verdict;
      if (bad_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Reset value, masked readback, narrow pass-through
   task automatic t_select;
      u_iocad_host.acc(1'h1, 1'h0, 16'h0CF8, 4'hF, 32'h0);
      chk({io_pass, io_rvalid, io_rdata}, {2'h1, 32'h0});
      u_iocad_host.acc(1'h1, 1'h1, 16'h0CF8, 4'hF, 32'hFFFFFFFF);
      u_iocad_host.acc(1'h1, 1'h0, 16'h0CF8, 4'hF, 32'h0);
      chk({io_pass, io_rvalid, io_rdata}, {2'h1, 32'h80FFFFFC});
      u_iocad_host.acc(1'h1, 1'h1, 16'h0CF8, 4'h3, 32'h0);
      chk({io_pass, io_rvalid}, 2'h2);
      u_iocad_host.acc(1'h1, 1'h0, 16'h0CF8, 4'hC, 32'h0);
      chk({io_pass, io_rvalid}, 2'h2);
      u_iocad_host.acc(1'h1, 1'h0, 16'h0CF8, 4'hF, 32'h0);
      chk({io_pass, io_rvalid, io_rdata}, {2'h1, 32'h80FFFFFC});
   endtask
   // Every route, back-to-back selector write then data access
   task automatic t_route;
      logic [31:0] sel [7] = '{32'h80000100, 32'h80000200, 32'h80001208, 32'h80090104, 32'h80050000,
                               32'h80080000, 32'h80030000};
      logic [2:0]  rt [7] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h3};
      for (int i = 0; i < 7; i++) begin
         u_iocad_host.acc(1'h1, 1'h1, 16'h0CF8, 4'hF, sel[i]);
         u_iocad_host.acc(1'h1, 1'h0, 16'h0CFC, 4'hF, 32'h0);
         chk({cfg_launch, cfg_route}, {1'h1, rt[i]});
         chk({hdr_byte8, hub_addr}, {sel[i][23:16], sel[i] & (rt[i] == 3'h3 ? 32'h00FFFFFC : 32'h0000FFFC)});
         chk({hdr_byte6, hdr_byte7, hdr_byte9}, {5'h00, sel[i][10:8], sel[i][7:2], 2'h0, sel[i][15:8]});
      end
   endtask
   // Enable gating, reserved bits ignored by routing
   task automatic t_gate;
      u_iocad_host.acc(1'h1, 1'h1, 16'h0CF8, 4'hF, 32'h00050000);
      u_iocad_host.acc(1'h1, 1'h1, 16'h0CFC, 4'hF, 32'h12345678);
      chk(cfg_launch, 1'h0);
      u_iocad_host.acc(1'h1, 1'h1, 16'h0CF8, 4'hF, 32'hFF050003);
      u_iocad_host.acc(1'h1, 1'h1, 16'h0CFC, 4'h3, 32'hA5A5A5A5);
      chk({cfg_launch, cfg_route, cfg_write, cfg_be, cfg_wdata}, {1'h1, 3'h4, 1'h1, 4'h3, 32'hA5A5A5A5});
      u_iocad_host.acc(1'h0, 1'h0, 16'h0000, 4'h0, 32'h0);
   endtask
   // Main sequence after 12 cycles of reset
   initial begin
      arst_n = 1'h0;
      repeat (12) @(posedge clk);
      #1 arst_n = 1'h1;
      t_select;
      t_route;
      t_gate;
      print_verdict;
   end
   // Watchdog
   initial begin
      #2000;
      bad_count++;
      print_verdict;
   end
endmodule
